/* File: logic/pscr_station_regs.sv */
// Behaviour
// - deskew level field sets lane delay; reads return auto or manual delay
// - manual enable bit picks auto balancing (0) or programmed level (1)
// - high deskew fields map to lanes 10-15, 26-31 or 42-47 per station
// - four read-write words hold test pattern bytes 0-15 for loopback
// - registers exist only at ports 0, 8 and 12, one per station
// - command bit 3 allows upstream crosslink as configuration master
// - command bit 4 allows downstream crosslink as configuration slave
// - command bit 5 set disables lane reversal during training
// - command bit 7 set disables elastic buffer low-latency mode
// - 8-bit fast training set count, reset value 40h, goes to training
// - read-only field reports number of ports in current configuration
// - eeprom port configuration value overrides station strap inputs
// - port configuration updates only on fundamental reset pin
// - code 1 gives x16, code 2 gives x8 x8, others x8 x4 x4
// - undefined port configuration codes behave as option zero
// - 3-bit field forces single ports to x1; don't-care bits ignored
// - test bit 0 shortens timer scale from milliseconds to microseconds
// - test bit 1 enables skip timer test mode
// - test parameters apply per serdes quad, station base lane offset
`timescale 1ns/1ps
`default_nettype none
module pscr_station_regs
    import pscr_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        fundamental_reset_pin,
    input  wire logic [3:0]  station_port_id,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [11:0] cfg_addr,
    input  wire logic [31:0] cfg_wdata,
    input  wire logic [3:0]  cfg_be,
    output var  logic [31:0] cfg_rdata,
    output var  logic        cfg_rvalid,
    input  wire logic        eeprom_cfg_valid,
    input  wire logic [2:0]  eeprom_port_cfg,
    input  wire logic [1:0]  station_layout_strap,
    input  wire logic [17:0] auto_deskew_delay,
    output var  logic [23:0] deskew_lane_ctrl,
    output var  logic [5:0]  deskew_lane_base,
    output var  logic [127:0] test_pattern,
    output var  logic        up_xlink_en,
    output var  logic        dn_xlink_en,
    output var  logic        lane_reversal_dis,
    output var  logic        low_latency_dis,
    output var  logic [7:0]  fast_training_set_count,
    output var  logic [2:0]  port_cfg,
    output var  logic [14:0] port_width,
    output var  logic [2:0]  x1_force,
    output var  logic        timer_test_en,
    output var  logic        skip_timer_test_en,
    output var  logic [5:0]  serdes_base
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [23:0]  deskew;
        logic [31:0]  pat0;
        logic [31:0]  pat1;
        logic [31:0]  pat2;
        logic [31:0]  pat3;
        logic [4:0]   cmd;
        logic [7:0]   nfts;
        logic [2:0]   nports;
        logic [2:0]   pcfg;
        logic [2:0]   x1;
        logic [1:0]   tst;
        logic [31:0]  rdata;
        logic         rvalid;
        logic [23:0]  dsk_out;
        logic [14:0]  width;
        logic [5:0]   lbase;
        logic [5:0]   sbase;
    } pscr_state_s;

    pscr_state_s st_ff;
    pscr_state_s nxt_st;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_be

    // unknown codes fold onto option zero
    function automatic pscr_cfg_e decode_cfg(input logic [2:0] c);
        case (c)
            3'b001:  return PSCR_CFG_X16;
            3'b010:  return PSCR_CFG_X8X8;
            default: return PSCR_CFG_X8X4X4;
        endcase
    endfunction : decode_cfg

    // ----------------------------------------------------------------
    // station presence
    // ----------------------------------------------------------------
    // any other port id owns no copy: writes drop, reads give zero
    logic station_valid;
    logic [5:0] lane_base_c;
    logic [5:0] serdes_base_c;
    always_comb begin
        station_valid = 1'b1;
        lane_base_c   = LANE_BASE_STN0;
        serdes_base_c = SERDES_BASE_STN0;
        case (station_port_id)
            STATION0_PORT: begin
                lane_base_c   = LANE_BASE_STN0;
                serdes_base_c = SERDES_BASE_STN0;
            end
            STATION1_PORT: begin
                lane_base_c   = LANE_BASE_STN1;
                serdes_base_c = SERDES_BASE_STN1;
            end
            STATION2_PORT: begin
                lane_base_c   = LANE_BASE_STN2;
                serdes_base_c = SERDES_BASE_STN2;
            end
            default: station_valid = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic [31:0] dsk_rd;
    logic [31:0] wr_word;
    pscr_cfg_e   cfg_dec;
    logic        wr_hit;
    always_comb begin
        nxt_st  = st_ff;
        dsk_rd  = 32'h0;
        wr_word = 32'h0;
        wr_hit  = cfg_wr && station_valid;
        cfg_dec = decode_cfg(st_ff.pcfg);

        // deskew read: manual lanes show their level, auto lanes the delay
        for (int l = 0; l < DSK_LANES; l++) begin
            dsk_rd[DSK_FIRST_BIT + l*DSK_FIELD_W + 3] =
                st_ff.deskew[l*4 + 3];
            dsk_rd[DSK_FIRST_BIT + l*DSK_FIELD_W +: 3] =
                st_ff.deskew[l*4 + 3] ? st_ff.deskew[l*4 +: 3]
                                      : auto_deskew_delay[l*3 +: 3];
        end

        if (wr_hit) begin
            case (cfg_addr)
                OFS_DESKEW_HIGH: begin
                    // lower byte holds other lanes, not kept here
                    // levels of auto lanes are kept as well and take
                    // effect once software sets the manual bit
                    wr_word = merge_be({st_ff.deskew, 8'h0}, cfg_wdata,
                                       cfg_be) & DSK_WMASK;
                    nxt_st.deskew = wr_word[31:8];
                end
                OFS_PATTERN_W0:
                    nxt_st.pat0 = merge_be(st_ff.pat0, cfg_wdata, cfg_be);
                OFS_PATTERN_W1:
                    nxt_st.pat1 = merge_be(st_ff.pat1, cfg_wdata, cfg_be);
                OFS_PATTERN_W2:
                    nxt_st.pat2 = merge_be(st_ff.pat2, cfg_wdata, cfg_be);
                OFS_PATTERN_W3:
                    nxt_st.pat3 = merge_be(st_ff.pat3, cfg_wdata, cfg_be);
                OFS_PHY_CMD: begin
                    // rebuild the stored word so unselected byte lanes
                    // keep their value; bits 22:20 are not writable
                    wr_word = merge_be({16'h0, st_ff.nfts, st_ff.cmd[4], 1'b0,
                                        st_ff.cmd[3:1], 3'b000},
                                       cfg_wdata, cfg_be);
                    nxt_st.cmd  = {wr_word[CMD_LOWLAT_DIS],
                                   wr_word[CMD_LREV_DIS],
                                   wr_word[CMD_DN_XLINK],
                                   wr_word[CMD_UP_XLINK],
                                   1'b0};
                    nxt_st.nfts = wr_word[CMD_NFTS_LSB +: 8];
                end
                OFS_PORT_LAYOUT: begin
                    if (cfg_be[1]) begin
                        nxt_st.x1 = cfg_wdata[LAY_X1_LSB +: 3];
                    end
                end
                OFS_PHY_TEST: begin
                    if (cfg_be[0]) begin
                        nxt_st.tst = {cfg_wdata[TST_SKIP],
                                      cfg_wdata[TST_TIMER]};
                    end
                end
                default: ;
            endcase
        end

        // a strap change after the pin drops waits for the next fundamental
        // reset, so ports can not be reshaped under a live link
        // port layout catches eeprom or strap only under fundamental reset
        if (fundamental_reset_pin) begin
            nxt_st.pcfg = eeprom_cfg_valid ? eeprom_port_cfg
                                           : {1'b0, station_layout_strap};
        end

        case (cfg_dec)
            PSCR_CFG_X16:  nxt_st.nports = NPORTS_X16;
            PSCR_CFG_X8X8: nxt_st.nports = NPORTS_X8X8;
            default:       nxt_st.nports = NPORTS_X8X4X4;
        endcase

        // widths per port: third, second, first of the station
        case (cfg_dec)
            PSCR_CFG_X16:
                nxt_st.width = {WIDTH_NONE, WIDTH_NONE, WIDTH_X16};
            PSCR_CFG_X8X8:
                nxt_st.width = {WIDTH_NONE, WIDTH_X8, WIDTH_X8};
            default:
                nxt_st.width = {WIDTH_X4, WIDTH_X4, WIDTH_X8};
        endcase
        for (int p = 0; p < 3; p++) begin
            // x1 force only narrows a port that exists
            if (st_ff.x1[p] && nxt_st.width[p*5 +: 5] != WIDTH_NONE) begin
                nxt_st.width[p*5 +: 5] = WIDTH_X1;
            end
        end

        // manual lanes drive their level, auto lanes the measured delay
        nxt_st.dsk_out = dsk_rd[31:8];
        nxt_st.lbase   = lane_base_c;
        nxt_st.sbase   = serdes_base_c;

        // a port without a copy still answers, with zero data, so the
        // bus never waits on a station that owns no registers
        nxt_st.rvalid = cfg_rd;
        nxt_st.rdata  = 32'h0;
        if (cfg_rd && station_valid) begin
            case (cfg_addr)
                OFS_DESKEW_HIGH: nxt_st.rdata = dsk_rd;
                OFS_PATTERN_W0:  nxt_st.rdata = st_ff.pat0;
                OFS_PATTERN_W1:  nxt_st.rdata = st_ff.pat1;
                OFS_PATTERN_W2:  nxt_st.rdata = st_ff.pat2;
                OFS_PATTERN_W3:  nxt_st.rdata = st_ff.pat3;
                OFS_PHY_CMD:
                    nxt_st.rdata = {9'h0, st_ff.nports, 4'h0, st_ff.nfts,
                                    st_ff.cmd[4], 1'b0, st_ff.cmd[3:1],
                                    3'b000};
                OFS_PORT_LAYOUT:
                    nxt_st.rdata = {21'h0, st_ff.x1, 5'h00, st_ff.pcfg};
                OFS_PHY_TEST:
                    nxt_st.rdata = {30'h0, st_ff.tst};
                default: nxt_st.rdata = 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_ff        <= '0;
            st_ff.nfts   <= NFTS_RESET;
            st_ff.nports <= NPORTS_X8X4X4;
            st_ff.width  <= {WIDTH_X4, WIDTH_X4, WIDTH_X8};
            // layout survives ordinary resets
            st_ff.pcfg   <= nxt_st.pcfg;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign cfg_rdata               = st_ff.rdata;
    assign cfg_rvalid              = st_ff.rvalid;
    assign deskew_lane_ctrl        = st_ff.dsk_out;
    assign deskew_lane_base        = st_ff.lbase;
    assign test_pattern            = {st_ff.pat3, st_ff.pat2,
                                      st_ff.pat1, st_ff.pat0};
    assign up_xlink_en             = st_ff.cmd[1];
    assign dn_xlink_en             = st_ff.cmd[2];
    assign lane_reversal_dis       = st_ff.cmd[3];
    assign low_latency_dis         = st_ff.cmd[4];
    assign fast_training_set_count = st_ff.nfts;
    assign port_cfg                = st_ff.pcfg;
    assign port_width              = st_ff.width;
    assign x1_force                = st_ff.x1;
    assign timer_test_en           = st_ff.tst[0];
    assign skip_timer_test_en      = st_ff.tst[1];
    assign serdes_base             = st_ff.sbase;
endmodule : pscr_station_regs
`default_nettype wire

/* File: shared/pscr_pkg.sv */
package pscr_pkg;
    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_DESKEW_HIGH  = 12'h20c;
    localparam logic [11:0] OFS_PATTERN_W0   = 12'h210;
    localparam logic [11:0] OFS_PATTERN_W1   = 12'h214;
    localparam logic [11:0] OFS_PATTERN_W2   = 12'h218;
    localparam logic [11:0] OFS_PATTERN_W3   = 12'h21c;
    localparam logic [11:0] OFS_PHY_CMD      = 12'h220;
    localparam logic [11:0] OFS_PORT_LAYOUT  = 12'h224;
    localparam logic [11:0] OFS_PHY_TEST     = 12'h228;
    localparam int          PATTERN_WORDS    = 4;

    // ----------------------------------------------------------------
    // station identity: registers live at ports 0, 8 and 12
    // ----------------------------------------------------------------
    localparam logic [3:0]  STATION0_PORT    = 4'h0;
    localparam logic [3:0]  STATION1_PORT    = 4'h8;
    localparam logic [3:0]  STATION2_PORT    = 4'hc;
    localparam logic [5:0]  LANE_BASE_STN0   = 6'h0a;
    localparam logic [5:0]  LANE_BASE_STN1   = 6'h1a;
    localparam logic [5:0]  LANE_BASE_STN2   = 6'h2a;
    localparam logic [5:0]  SERDES_BASE_STN0 = 6'h00;
    localparam logic [5:0]  SERDES_BASE_STN1 = 6'h10;
    localparam logic [5:0]  SERDES_BASE_STN2 = 6'h20;

    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int          DSK_LANES        = 6;
    localparam int          DSK_FIRST_BIT    = 8;
    localparam int          DSK_FIELD_W      = 4;
    localparam logic [31:0] DSK_WMASK        = 32'hffffff00;
    localparam int          CMD_UP_XLINK     = 3;
    localparam int          CMD_DN_XLINK     = 4;
    localparam int          CMD_LREV_DIS     = 5;
    localparam int          CMD_LOWLAT_DIS   = 7;
    localparam int          CMD_NFTS_LSB     = 8;
    localparam int          CMD_NPORTS_LSB   = 20;
    localparam logic [7:0]  NFTS_RESET       = 8'h40;
    localparam int          LAY_X1_LSB       = 8;
    localparam int          TST_TIMER        = 0;
    localparam int          TST_SKIP         = 1;

    // ----------------------------------------------------------------
    // port configuration encodings
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PSCR_CFG_X8X4X4 = 3'b000,
        PSCR_CFG_X16    = 3'b001,
        PSCR_CFG_X8X8   = 3'b010
    } pscr_cfg_e;
    localparam logic [2:0]  NPORTS_X8X4X4    = 3'h3;
    localparam logic [2:0]  NPORTS_X16       = 3'h1;
    localparam logic [2:0]  NPORTS_X8X8      = 3'h2;
    localparam logic [4:0]  WIDTH_X16        = 5'h10;
    localparam logic [4:0]  WIDTH_X8         = 5'h08;
    localparam logic [4:0]  WIDTH_X4         = 5'h04;
    localparam logic [4:0]  WIDTH_X1         = 5'h01;
    localparam logic [4:0]  WIDTH_NONE       = 5'h00;
endpackage : pscr_pkg

/* File: tb/pscr_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module pscr_asserts
    import pscr_pkg::*;
(
    input wire logic         ref_clk,
    input wire logic         srst,
    input wire logic         fundamental_reset_pin,
    input wire logic [3:0]   station_port_id,
    input wire logic         cfg_wr,
    input wire logic [11:0]  cfg_addr,
    input wire logic [31:0]  cfg_wdata,
    input wire logic [3:0]   cfg_be,
    input wire logic         eeprom_cfg_valid,
    input wire logic [2:0]   eeprom_port_cfg,
    input wire logic         up_xlink_en,
    input wire logic [7:0]   fast_training_set_count,
    input wire logic [2:0]   port_cfg,
    input wire logic [14:0]  port_width,
    input wire logic [2:0]   x1_force,
    input wire logic [127:0] test_pattern,
    input wire logic         timer_test_en,
    input wire logic         skip_timer_test_en
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic stn_ok;
    logic wr_ok;
    assign stn_ok = station_port_id inside {STATION0_PORT, STATION1_PORT,
                                            STATION2_PORT};
    assign wr_ok = cfg_wr && stn_ok;
    property p_up_xlink;
        wr_ok && cfg_addr == OFS_PHY_CMD && cfg_be[0]
            |=> up_xlink_en == $past(cfg_wdata[3]);
    endproperty
    a_up_xlink: assert property (p_up_xlink) else $error("crosslink bit");
    property p_fts;
        wr_ok && cfg_addr == OFS_PHY_CMD && cfg_be[1]
            |=> fast_training_set_count == $past(cfg_wdata[15:8]);
    endproperty
    a_fts: assert property (p_fts) else $error("training set count");
    property p_pattern;
        wr_ok && cfg_addr == OFS_PATTERN_W3 && cfg_be == 4'hf
            |=> test_pattern[127:96] == $past(cfg_wdata);
    endproperty
    a_pattern: assert property (p_pattern) else $error("pattern word");
    property p_test_bits;
        wr_ok && cfg_addr == OFS_PHY_TEST && cfg_be[0]
            |=> {skip_timer_test_en, timer_test_en} == $past(cfg_wdata[1:0]);
    endproperty
    a_test_bits: assert property (p_test_bits) else $error("test bits");
    property p_cfg_hold;
        !fundamental_reset_pin |=> $stable(port_cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("layout moved");
    property p_cfg_load;
        fundamental_reset_pin && eeprom_cfg_valid
            |=> port_cfg == $past(eeprom_port_cfg);
    endproperty
    a_cfg_load: assert property (p_cfg_load) else $error("image ignored");
    property p_x16;
        (port_cfg == PSCR_CFG_X16 && !x1_force[0])[*2]
            |-> port_width == {10'h0, WIDTH_X16};
    endproperty
    a_x16: assert property (p_x16) else $error("x16 widths");
    property p_default;
        (port_cfg > 3'h2 && x1_force == 3'h0)[*2]
            |-> port_width == {WIDTH_X4, WIDTH_X4, WIDTH_X8};
    endproperty
    a_default: assert property (p_default) else $error("option widths");
    property p_bad_station;
        cfg_wr && !stn_ok
            |=> $stable(test_pattern) && $stable(fast_training_set_count);
    endproperty
    a_bad_station: assert property (p_bad_station) else $error("stray write");
endmodule : pscr_asserts
bind pscr_station_regs pscr_asserts i_chk (.ref_clk, .srst,
    .fundamental_reset_pin, .station_port_id, .cfg_wr, .cfg_addr, .cfg_wdata,
    .cfg_be, .eeprom_cfg_valid, .eeprom_port_cfg, .up_xlink_en,
    .fast_training_set_count, .port_cfg, .port_width, .x1_force,
    .test_pattern, .timer_test_en, .skip_timer_test_en);
`default_nettype wire

/* File: tb/pscr_eeprom_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pscr_eeprom_model (
    input  wire logic       ref_clk,
    input  wire logic       present,
    input  wire logic [2:0] image_cfg,
    output var  logic       eeprom_cfg_valid,
    output var  logic [2:0] eeprom_port_cfg
);
    // without an image the data lines carry junk, never a held value
    always @(posedge ref_clk) begin
        eeprom_cfg_valid <= present;
        eeprom_port_cfg  <= present ? image_cfg : ~eeprom_port_cfg;
    end
endmodule : pscr_eeprom_model
`default_nettype wire

/* File: tb/tb_phy_station_config_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_phy_station_config_regs;
    import pscr_pkg::*;
    logic         ref_clk = 1'b0;
    logic         srst = 1'b1;
    logic         fundamental_reset_pin = 1'b1;
    logic [3:0]   station_port_id = 4'h0;
    logic         cfg_wr = 1'b0, cfg_rd = 1'b0, ee_present = 1'b1;
    logic [11:0]  cfg_addr = 12'h0;
    logic [31:0]  cfg_wdata = 32'h0, cfg_rdata, w, seed = 32'h18;
    logic [3:0]   cfg_be = 4'h0;
    logic [1:0]   station_layout_strap = 2'h0;
    logic [17:0]  auto_deskew_delay = 18'h0;
    logic [2:0]   ee_image = 3'h5, eeprom_port_cfg, port_cfg, x1_force;
    logic         cfg_rvalid, eeprom_cfg_valid, up_xlink_en, dn_xlink_en;
    logic         lane_reversal_dis, low_latency_dis, timer_test_en;
    logic         skip_timer_test_en;
    logic [23:0]  deskew_lane_ctrl;
    logic [5:0]   deskew_lane_base, serdes_base;
    logic [127:0] test_pattern;
    logic [7:0]   fast_training_set_count;
    logic [14:0]  port_width;
    logic [31:0]  expq[$];
    logic [2:0]   codes [3] = '{3'h1, 3'h2, 3'h7};
    logic [3:0]   stns [4] = '{4'h0, 4'h8, 4'hc, 4'h4};
    int           errors = 0;
    int           comparisons = 0;
    always #10 ref_clk = ~ref_clk;
    pscr_eeprom_model i_ee (.ref_clk, .present(ee_present),
        .image_cfg(ee_image), .eeprom_cfg_valid, .eeprom_port_cfg);
    pscr_station_regs i_dut (.ref_clk, .srst, .fundamental_reset_pin,
        .station_port_id, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_be,
        .cfg_rdata, .cfg_rvalid, .eeprom_cfg_valid, .eeprom_port_cfg,
        .station_layout_strap, .auto_deskew_delay, .deskew_lane_ctrl,
        .deskew_lane_base, .test_pattern, .up_xlink_en, .dn_xlink_en,
        .lane_reversal_dis, .low_latency_dis, .fast_training_set_count,
        .port_cfg, .port_width, .x1_force, .timer_test_en,
        .skip_timer_test_en, .serdes_base);
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [31:0] dsk_exp(input logic [31:0] d,
                                            input logic [17:0] a);
        logic [31:0] r;
        r = 32'h0;
        for (int k = 0; k < DSK_LANES; k++) begin
            r[4*k+11] = d[4*k+11];
            r[4*k+8 +: 3] = d[4*k+11] ? d[4*k+8 +: 3] : a[3*k +: 3];
        end
        return r;
    endfunction : dsk_exp
    function automatic logic [14:0] wid_exp(input logic [2:0] c,
                                            input logic [2:0] f);
        logic [4:0] pw [3];
        pw = '{WIDTH_X8, WIDTH_X4, WIDTH_X4};
        if (c == PSCR_CFG_X16) pw = '{WIDTH_X16, WIDTH_NONE, WIDTH_NONE};
        if (c == PSCR_CFG_X8X8) pw = '{WIDTH_X8, WIDTH_X8, WIDTH_NONE};
        for (int p = 0; p < 3; p++)
            if (f[p] && pw[p] != WIDTH_NONE) pw[p] = WIDTH_X1;
        return {pw[2], pw[1], pw[0]};
    endfunction : wid_exp
    function automatic logic [31:0] cmd_exp(input logic [2:0] c);
        logic [2:0] n;
        n = c == 3'h1 ? NPORTS_X16 : c == 3'h2 ? NPORTS_X8X8 : NPORTS_X8X4X4;
        return 32'h00002008 | (32'(n) << 20);
    endfunction : cmd_exp
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] b);
        tick();
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        cfg_be = b;
        tick();
        cfg_wr = 1'b0;
        tick();
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        tick();
        expq.push_back(e);
        cfg_rd = 1'b1;
        cfg_addr = a;
        tick();
        cfg_rd = 1'b0;
    endtask : rd
    task automatic fres(input logic p, input logic [2:0] img);
        tick();
        ee_present = p;
        ee_image = img;
        station_layout_strap = 2'h1;
        fundamental_reset_pin = 1'b1;
        repeat (3) tick();
        fundamental_reset_pin = 1'b0;
        repeat (2) tick();
    endtask : fres
    task automatic complete_run();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    // read data launched at a rising edge is looked at on the falling one
    always @(negedge ref_clk) begin
        if (cfg_rvalid === 1'b1) begin
            if (expq.size() == 0) begin
                errors++;
                $display("Error at %0t ns: got %h with no read pending",
                         $time, cfg_rdata);
            end else begin
                chk(cfg_rdata, expq.pop_front());
            end
        end
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        complete_run();
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        w = rnd();
        auto_deskew_delay = w[17:0];
        repeat (12) tick();
        srst = 1'b0;
        fres(1'b1, 3'h5);
        rd(OFS_DESKEW_HIGH, dsk_exp(32'h0, auto_deskew_delay));
        for (int i = 0; i < PATTERN_WORDS; i++)
            rd(OFS_PATTERN_W0 + 12'(4 * i), 32'h0);
        rd(OFS_PHY_CMD, 32'h00304000);
        rd(OFS_PORT_LAYOUT, 32'h5);
        rd(OFS_PHY_TEST, 32'h0);
        rd(12'h230, 32'h0);
        wr(OFS_PHY_CMD, 32'hffffffff, 4'hf);
        chk(32'({up_xlink_en, dn_xlink_en, lane_reversal_dis, low_latency_dis,
                 fast_training_set_count}), 32'hfff);
        rd(OFS_PHY_CMD, 32'h0030ffb8);
        wr(OFS_PHY_CMD, 32'h0000ff00, 4'h1);
        rd(OFS_PHY_CMD, 32'h0030ff00);
        wr(OFS_PHY_CMD, 32'h00002008, 4'hf);
        chk(32'({up_xlink_en, dn_xlink_en, lane_reversal_dis, low_latency_dis,
                 fast_training_set_count}), 32'h820);
        for (int i = 0; i < PATTERN_WORDS; i++) begin
            w = rnd();
            wr(OFS_PATTERN_W0 + 12'(4 * i), w, 4'hf);
            chk(test_pattern[32*i +: 32], w);
            rd(OFS_PATTERN_W0 + 12'(4 * i), w);
        end
        wr(OFS_PATTERN_W3, ~w, 4'h5);
        rd(OFS_PATTERN_W3, (w & 32'hff00ff00) | (~w & 32'h00ff00ff));
        // auto to manual is only advice, so the block must still take it
        w = rnd();
        wr(OFS_DESKEW_HIGH, w, 4'hf);
        for (int j = 0; j < 2; j++) begin
            chk(32'(deskew_lane_ctrl), dsk_exp(w, auto_deskew_delay) >> 8);
            rd(OFS_DESKEW_HIGH, dsk_exp(w, auto_deskew_delay));
            auto_deskew_delay = ~auto_deskew_delay;
            repeat (2) tick();
        end
        wr(OFS_PHY_TEST, 32'hffffffff, 4'hf);
        chk(32'({skip_timer_test_en, timer_test_en}), 32'h3);
        rd(OFS_PHY_TEST, 32'h3);
        wr(OFS_PHY_TEST, 32'h2, 4'hf);
        chk(32'({skip_timer_test_en, timer_test_en}), 32'h2);
        wr(OFS_PORT_LAYOUT, 32'hffffffff, 4'hf);
        rd(OFS_PORT_LAYOUT, 32'h705);
        chk(32'(x1_force), 32'h7);
        chk(32'(port_width), 32'(wid_exp(3'h5, 3'h7)));
        wr(OFS_PORT_LAYOUT, 32'h00000200, 4'hf);
        for (int i = 0; i < 3; i++) begin
            fres(i != 0, codes[i]);
            chk(32'(port_cfg), 32'(codes[i]));
            chk(32'(port_width), 32'(wid_exp(codes[i], 3'h2)));
            rd(OFS_PHY_CMD, cmd_exp(codes[i]));
        end
        srst = 1'b1;
        tick();
        srst = 1'b0;
        repeat (2) tick();
        chk(32'(port_cfg), 32'h7);
        chk(32'(fast_training_set_count), 32'h40);
        for (int i = 0; i < 4; i++) begin
            station_port_id = stns[i];
            wr(OFS_PHY_CMD, i < 3 ? 32'h0000ff00 : 32'h00001100, 4'hf);
            rd(OFS_PHY_CMD, i < 3 ? 32'h0030ff00 : 32'h0);
            chk(32'(fast_training_set_count), 32'hff);
            if (i < 3)
                chk(32'({deskew_lane_base, serdes_base}),
                    32'({6'(6'ha + 6'h10 * i), 6'(6'h10 * i)}));
        end
        repeat (3) tick();
        if (expq.size() != 0) errors++;
        complete_run();
    end
endmodule : tb_phy_station_config_regs
`default_nettype wire
